// [core/acbp_device.sv]
// acbp_device: device end of the control bus, a bank of 64 byte registers
// assumes the host keeps its lines valid while its enable is low
`timescale 1ns/1ns
`default_nettype none
`include "acbp_params.svh"

module acbp_device
  import acbp_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  // control bus
  acbp_if.dev             bus,
  // internal event sources, one-cycle pulses into the cause register
  input  wire acbp_byte_t i_irq_event,
  // report of every accepted register write
  output logic            o_wr_stb,
  output acbp_addr_t      o_wr_addr,
  output acbp_byte_t      o_wr_data,
  // report of every refused write
  output logic            o_par_err_stb
);

  // enable synchroniser
  logic            ce_meta;
  logic            ce_sync;
  // cycle state
  acbp_dev_state_t state;
  acbp_dev_state_t next_state;
  // register bank and interrupt registers
  acbp_byte_t      regs [0:`ACBP_NUM_REGS-1];
  acbp_byte_t      irq_cause_reg;
  acbp_byte_t      irq_mask_reg;
  acbp_byte_t      next_cause;
  // decode of the access taken this cycle
  logic            start;
  logic            is_read;
  logic            par_ok;
  logic            wr_ok;
  logic            wr_bad;
  acbp_addr_t      addr;
  acbp_byte_t      rd_byte;
  acbp_byte_t      cause_clr;
  acbp_byte_t      cause_set;

  // two-flop synchroniser on the enable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ce_meta <= 1'b1;
      ce_sync <= 1'b1;
    end else if (i_clk_en) begin
      ce_meta <= bus.ce_n;
      ce_sync <= ce_meta;
    end
  end

  // one access when a synchronised low enable is seen in idle
  assign start   = (state == ACBP_DEV_IDLE) && !ce_sync;
  assign is_read = bus.rd_wr;
  assign addr    = bus.ctl_addr;
  assign par_ok  = (bus.ctl_parity == acbp_odd_par(bus.ctl_data));
  assign wr_ok   = start && !is_read && par_ok;
  assign wr_bad  = start && !is_read && !par_ok;

  // state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ACBP_DEV_IDLE: begin
        if (start) begin
          next_state = ACBP_DEV_ACK;
        end
      end
      ACBP_DEV_ACK: begin
        if (ce_sync) begin
          next_state = ACBP_DEV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ACBP_DEV_IDLE;
    end else if (i_clk_en) begin
      state <= next_state;
    end
  end

  // read multiplexer over the bank and interrupt registers
  always_comb begin
    if (addr == `ACBP_ICR_ADDR) begin
      rd_byte = irq_cause_reg;
    end else if (addr == `ACBP_IMR_ADDR) begin
      rd_byte = irq_mask_reg;
    end else begin
      rd_byte = regs[addr];
    end
  end

  // general register bank, written only on good parity
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `ACBP_NUM_REGS; i++) begin
        regs[i] <= `ACBP_REG_RST;
      end
    end else if (i_clk_en) begin
      if (wr_ok && addr != `ACBP_ICR_ADDR && addr != `ACBP_IMR_ADDR) begin
        regs[addr] <= bus.ctl_data;
      end
    end
  end

  // mask register, a set bit lets its cause through
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_reg <= `ACBP_IMR_RST;
    end else if (i_clk_en) begin
      if (wr_ok && addr == `ACBP_IMR_ADDR) begin
        irq_mask_reg <= bus.ctl_data;
      end
    end
  end

  // cause register: write one clears, a new event wins over its clear
  always_comb begin
    cause_clr = '0;
    if (wr_ok && addr == `ACBP_ICR_ADDR) begin
      cause_clr = bus.ctl_data;
    end
    cause_set = i_irq_event;
    cause_set[`ACBP_WPE_BIT] = i_irq_event[`ACBP_WPE_BIT] | wr_bad;
    next_cause = (irq_cause_reg & ~cause_clr) | cause_set;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_cause_reg <= `ACBP_ICR_RST;
    end else if (i_clk_en) begin
      irq_cause_reg <= next_cause;
    end
  end

  // interrupt line pulled low while any unmasked cause is set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.int_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      bus.int_oe_n <= ~|(next_cause & irq_mask_reg);
    end
  end

  // acknowledge: pulled low with the access, released after enable rises
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.ack_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      if (start) begin
        bus.ack_oe_n <= 1'b0;
      end else if (state == ACBP_DEV_ACK && ce_sync) begin
        bus.ack_oe_n <= 1'b1;
      end
    end
  end

  // read data and parity, driven from the acknowledge edge until release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.dev_oe_n   <= 1'b1;
      bus.dev_data_o <= `ACBP_REG_RST;
      bus.dev_par_o  <= 1'b1;
    end else if (i_clk_en) begin
      if (start && is_read) begin
        bus.dev_oe_n   <= 1'b0;
        bus.dev_data_o <= rd_byte;
        bus.dev_par_o  <= acbp_odd_par(rd_byte);
      end else if (state == ACBP_DEV_ACK && ce_sync) begin
        bus.dev_oe_n <= 1'b1;
      end
    end
  end

  // user-side reports of accepted and refused writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_stb      <= 1'b0;
      o_wr_addr     <= '0;
      o_wr_data     <= `ACBP_REG_RST;
      o_par_err_stb <= 1'b0;
    end else if (i_clk_en) begin
      o_wr_stb      <= wr_ok;
      o_par_err_stb <= wr_bad;
      if (wr_ok) begin
        o_wr_addr <= addr;
        o_wr_data <= bus.ctl_data;
      end
    end
  end

endmodule

`default_nettype wire

// [core/acbp_params.svh]
// acbp_params.svh: constants of the asynchronous control bus port
// assumes inclusion by bare name from the package and both ends
`ifndef ACBP_PARAMS_SVH
`define ACBP_PARAMS_SVH

// bus widths and register bank size
`define ACBP_ADDR_W      6
`define ACBP_DATA_W      8
`define ACBP_NUM_REGS    64

// locations of the interrupt registers inside the bank
`define ACBP_ICR_ADDR    6'h00
`define ACBP_IMR_ADDR    6'h01

// bit of the cause register flagged on a bad-parity write
`define ACBP_WPE_BIT     0

// reset values
`define ACBP_REG_RST     8'h00
`define ACBP_ICR_RST     8'h00
`define ACBP_IMR_RST     8'h00

// level of a released open-drain or undriven line
`define ACBP_IDLE_BYTE   8'hFF

`endif

// [core/acbp_pkg.sv]
// acbp_pkg: types and shared functions of the control bus port
// assumes acbp_params.svh is on the include path
`include "acbp_params.svh"

package acbp_pkg;

  typedef logic [`ACBP_ADDR_W-1:0] acbp_addr_t;
  typedef logic [`ACBP_DATA_W-1:0] acbp_byte_t;

  // device end: idle or holding acknowledge
  typedef enum logic [0:0] {
    ACBP_DEV_IDLE = 1'b0,
    ACBP_DEV_ACK  = 1'b1
  } acbp_dev_state_t;

  // host end: idle, waiting for acknowledge, waiting for release
  typedef enum logic [1:0] {
    ACBP_HOST_IDLE = 2'b00,
    ACBP_HOST_WAIT = 2'b01,
    ACBP_HOST_REL  = 2'b10
  } acbp_host_state_t;

  // odd parity bit over a data byte
  function automatic logic acbp_odd_par(input acbp_byte_t data);
    acbp_odd_par = ~(^data);
  endfunction

endpackage

// [core/acbp_if.sv]
// acbp_if: control bus wires between host and device
// assumes both ends drive enables low to drive a line; released lines read high
`timescale 1ns/1ns
`default_nettype none
`include "acbp_params.svh"

interface acbp_if;
  import acbp_pkg::*;

  // host-driven lines
  logic       ce_n;
  logic       rd_wr;
  acbp_addr_t ctl_addr;
  acbp_byte_t host_data_o;
  logic       host_par_o;
  logic       host_oe_n;
  // device-driven lines
  acbp_byte_t dev_data_o;
  logic       dev_par_o;
  logic       dev_oe_n;
  logic       ack_oe_n;
  logic       int_oe_n;
  // resolved wires
  acbp_byte_t ctl_data;
  logic       ctl_parity;
  logic       ack_n;
  logic       int_n;

  // shared data and parity lines, pulled high when nobody drives
  assign ctl_data   = !dev_oe_n ? dev_data_o :
                      (!host_oe_n ? host_data_o : `ACBP_IDLE_BYTE);
  assign ctl_parity = !dev_oe_n ? dev_par_o : (!host_oe_n ? host_par_o : 1'b1);
  // open-drain lines pulled low while enabled
  assign ack_n = ack_oe_n;
  assign int_n = int_oe_n;

  modport dev (
    input  ce_n, rd_wr, ctl_addr, ctl_data, ctl_parity,
    output dev_data_o, dev_par_o, dev_oe_n, ack_oe_n, int_oe_n
  );

  modport host (
    input  ctl_data, ctl_parity, ack_n, int_n,
    output ce_n, rd_wr, ctl_addr, host_data_o, host_par_o, host_oe_n
  );

endinterface

`default_nettype wire

// [core/acbp_host.sv]
// acbp_host: host end of the control bus, one cycle per user request
// assumes the device answers every enable with an acknowledge
`timescale 1ns/1ns
`default_nettype none
`include "acbp_params.svh"

module acbp_host
  import acbp_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  // control bus
  acbp_if.host            bus,
  // user request
  input  wire logic       i_req,
  input  wire logic       i_rd,
  input  wire acbp_addr_t i_addr,
  input  wire acbp_byte_t i_wdata,
  input  wire logic       i_bad_par,
  // user answer
  output logic            o_busy,
  output logic            o_done,
  output acbp_byte_t      o_rdata,
  output logic            o_rpar_err,
  output logic            o_int
);

  // acknowledge and interrupt synchronisers
  logic             ack_meta;
  logic             ack_sync;
  logic             int_meta;
  acbp_host_state_t state;
  logic             take;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_meta <= 1'b1;
      ack_sync <= 1'b1;
      int_meta <= 1'b1;
      o_int    <= 1'b0;
    end else if (i_clk_en) begin
      ack_meta <= bus.ack_n;
      ack_sync <= ack_meta;
      int_meta <= bus.int_n;
      o_int    <= ~int_meta;
    end
  end

  assign take = (state == ACBP_HOST_IDLE) && i_req;

  // cycle sequencing and pin drive
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state           <= ACBP_HOST_IDLE;
      bus.ce_n        <= 1'b1;
      bus.rd_wr       <= 1'b1;
      bus.ctl_addr    <= '0;
      bus.host_data_o <= `ACBP_REG_RST;
      bus.host_par_o  <= 1'b1;
      bus.host_oe_n   <= 1'b1;
    end else if (i_clk_en) begin
      unique case (state)
        ACBP_HOST_IDLE: begin
          if (take) begin
            // every line valid in the cycle enable falls
            bus.ce_n        <= 1'b0;
            bus.rd_wr       <= i_rd;
            bus.ctl_addr    <= i_addr;
            bus.host_data_o <= i_wdata;
            bus.host_par_o  <= acbp_odd_par(i_wdata) ^ i_bad_par;
            bus.host_oe_n   <= i_rd;
            state           <= ACBP_HOST_WAIT;
          end
        end
        ACBP_HOST_WAIT: begin
          if (!ack_sync) begin
            bus.ce_n      <= 1'b1;
            bus.host_oe_n <= 1'b1;
            state         <= ACBP_HOST_REL;
          end
        end
        ACBP_HOST_REL: begin
          if (ack_sync) begin
            state <= ACBP_HOST_IDLE;
          end
        end
        default: begin
          state <= ACBP_HOST_IDLE;
        end
      endcase
    end
  end

  // user answer: read byte caught while acknowledge is low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
      o_rdata    <= `ACBP_REG_RST;
      o_rpar_err <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= (state == ACBP_HOST_REL) && ack_sync;
      if (take) begin
        o_busy <= 1'b1;
      end else if (state == ACBP_HOST_REL && ack_sync) begin
        o_busy <= 1'b0;
      end
      if (state == ACBP_HOST_WAIT && !ack_sync && bus.rd_wr) begin
        o_rdata    <= bus.ctl_data;
        o_rpar_err <= bus.ctl_parity != acbp_odd_par(bus.ctl_data);
      end
    end
  end

endmodule

`default_nettype wire

// [verif/acbp_port_sva.sv]
// acbp_port_sva: wire-level checks of the control bus
// assumes its inputs are taken straight from the interface joining both ends
`timescale 1ns/1ns
`default_nettype none

module acbp_port_sva
  import acbp_pkg::*;
(
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // bus wires
  input wire logic       ce_n,
  input wire logic       rd_wr,
  input wire acbp_addr_t ctl_addr,
  input wire logic       ack_n,
  input wire logic       dev_oe_n,
  input wire logic       host_oe_n,
  input wire acbp_byte_t ctl_data,
  input wire logic       ctl_parity
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // acknowledge follows enable within the sync delay
  ack_answer_a: assert property ($fell(ce_n) |-> ##[2:4] !ack_n)
    else $error("acknowledge missing after enable");
  ack_hold_a: assert property (!ack_n && !ce_n |=> !ack_n)
    else $error("acknowledge dropped while enable low");
  ack_free_a: assert property (ce_n [*4] |-> ack_n)
    else $error("acknowledge held after enable release");
  // read data driven, stable and with odd parity
  rd_par_a: assert property (!ack_n && !dev_oe_n |-> ctl_parity == ~(^ctl_data))
    else $error("read parity not odd");
  rd_hold_a: assert property (!ack_n && $past(!ack_n) && rd_wr
    |-> $stable(ctl_data) && $stable(ctl_parity))
    else $error("read byte moved during acknowledge");
  rd_drive_a: assert property (!ack_n && rd_wr |-> !dev_oe_n)
    else $error("device not driving read byte");
  wr_float_a: assert property (!ack_n && !rd_wr |-> dev_oe_n)
    else $error("device drives data on a write");
  no_fight_a: assert property (!(!dev_oe_n && !host_oe_n))
    else $error("both ends drive the data lines");
  // host keeps its request lines and write byte still while enable is low
  addr_hold_a: assert property (!ce_n && $past(!ce_n) |-> $stable(ctl_addr) && $stable(rd_wr))
    else $error("address or select moved while enable low");
  wr_hold_a: assert property (!ce_n && !rd_wr && $past(!ce_n)
    |-> !host_oe_n && $stable(ctl_data) && $stable(ctl_parity))
    else $error("write byte not held while enable low");
endmodule

`default_nettype wire

// [verif/async_control_bus_port_bench.sv]
// async_control_bus_port_bench: host and device ends joined back to back
// assumes the design files and acbp_port_sva are compiled before it
`timescale 1ns/1ns
`default_nettype none

module async_control_bus_port_bench;
  import acbp_pkg::*;
  typedef struct packed {logic rd; acbp_byte_t data;} acbp_note_t;

  logic       i_clk, i_rst, req, rd, bad_par, busy, done, rpar_err, irq, wr_stb, par_err_stb;
  acbp_addr_t addr, wr_addr;
  acbp_byte_t wdata, rdata, irq_event, a_data, wr_data, r_data;
  logic [13:0] wr_notes [$];
  logic [13:0] wnote;
  acbp_byte_t exp_reg [64];
  acbp_note_t notes [$];
  acbp_note_t note;
  int         checks, err_total, wr_seen, pe_seen, wr_exp, pe_exp, seed;

  acbp_if acbp_if_inst ();
  acbp_device acbp_device_inst (.i_clk(i_clk), .i_rst(i_rst), .i_clk_en(1'b1),
    .bus(acbp_if_inst.dev), .i_irq_event(irq_event), .o_wr_stb(wr_stb),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_par_err_stb(par_err_stb));
  acbp_host acbp_host_inst (.i_clk(i_clk), .i_rst(i_rst), .i_clk_en(1'b1),
    .bus(acbp_if_inst.host), .i_req(req), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .i_bad_par(bad_par), .o_busy(busy), .o_done(done), .o_rdata(rdata),
    .o_rpar_err(rpar_err), .o_int(irq));
  acbp_port_sva acbp_port_sva_inst (.i_clk(i_clk), .i_rst(i_rst),
    .ce_n(acbp_if_inst.ce_n), .rd_wr(acbp_if_inst.rd_wr), .ctl_addr(acbp_if_inst.ctl_addr),
    .ack_n(acbp_if_inst.ack_n),
    .dev_oe_n(acbp_if_inst.dev_oe_n), .host_oe_n(acbp_if_inst.host_oe_n),
    .ctl_data(acbp_if_inst.ctl_data), .ctl_parity(acbp_if_inst.ctl_parity));

  // clock source
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input acbp_byte_t seen, input acbp_byte_t expv);
    checks++;
    if (seen !== expv) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one bus cycle; notes the expected answer and updates the register model
  task automatic xfer(input logic r, input acbp_addr_t a, input acbp_byte_t d,
                      input logic bad);
    int n;
    notes.push_back('{r, exp_reg[a]});
    if (!r && bad) begin
      exp_reg[0] |= 8'h01;
      pe_exp++;
    end else if (!r) begin
      wr_exp++;
      wr_notes.push_back({a, d});
      if (a == 6'h00) exp_reg[0] &= ~d;
      else exp_reg[a] = d;
    end
    @(posedge i_clk);
    req     <= 1'b1;
    rd      <= r;
    addr    <= a;
    wdata   <= d;
    bad_par <= bad;
    @(posedge i_clk);
    req <= 1'b0;
    @(posedge i_clk);
    chk({7'h00, busy}, 8'h01);
    n = 0;
    while (n < 40 && done !== 1'b1) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      conclude();
    end
  endtask

  // bounded wait for the interrupt level
  task automatic wait_int(input logic v);
    int n;
    n = 0;
    while (n < 10 && irq !== v) begin
      @(posedge i_clk);
      n++;
    end
    chk({7'h00, irq}, {7'h00, v});
    if (irq !== v) conclude();
  endtask

  // answer checker and strobe counters
  always @(posedge i_clk) begin
    if (wr_stb === 1'b1) begin
      wr_seen++;
      if (wr_notes.size() == 0) chk(8'h01, 8'h00);
      else begin
        wnote = wr_notes.pop_front();
        chk({2'b00, wr_addr}, {2'b00, wnote[13:8]});
        chk(wr_data, wnote[7:0]);
      end
    end
    if (par_err_stb === 1'b1) pe_seen++;
    if (done === 1'b1) begin
      if (notes.size() == 0) chk(8'h01, 8'h00);
      else begin
        note = notes.pop_front();
        if (note.rd) begin
          chk(rdata, note.data);
          chk({7'h00, rpar_err}, 8'h00);
        end
      end
    end
  end

  // main sequence
  initial begin
    seed = 76;
    i_rst = 1'b1;
    {req, rd, bad_par, addr, wdata, irq_event} = '0;
    exp_reg = '{default: 8'h00};
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values at both ends of the bank
    xfer(1'b1, 6'h00, 8'h00, 1'b0);
    xfer(1'b1, 6'h3F, 8'h00, 1'b0);
    // random writes, each read back at once
    for (int i = 0; i < 20; i++) begin
      a_data = 8'($unsigned($random(seed)) % 62 + 2);
      r_data = 8'($random(seed));
      xfer(1'b0, a_data[5:0], r_data, 1'b0);
      xfer(1'b1, a_data[5:0], 8'h00, 1'b0);
    end
    // refused write leaves storage alone and flags the cause
    xfer(1'b0, 6'h05, 8'h5A, 1'b1);
    xfer(1'b1, 6'h05, 8'h00, 1'b0);
    xfer(1'b1, 6'h00, 8'h00, 1'b0);
    wait_int(1'b0);
    xfer(1'b0, 6'h01, 8'h01, 1'b0);
    wait_int(1'b1);
    xfer(1'b0, 6'h00, 8'h01, 1'b0);
    wait_int(1'b0);
    // event source behind the mask
    xfer(1'b0, 6'h01, 8'h02, 1'b0);
    @(posedge i_clk);
    irq_event <= 8'h02;
    exp_reg[0] |= 8'h02;
    @(posedge i_clk);
    irq_event <= 8'h00;
    wait_int(1'b1);
    xfer(1'b1, 6'h00, 8'h00, 1'b0);
    xfer(1'b0, 6'h00, 8'hFF, 1'b0);
    wait_int(1'b0);
    // sweep the whole bank
    for (int i = 0; i < 64; i++) xfer(1'b1, 6'(i), 8'h00, 1'b0);
    repeat (4) @(posedge i_clk);
    chk(8'(wr_seen), 8'(wr_exp));
    chk(8'(pe_seen), 8'(pe_exp));
    chk(8'(notes.size()), 8'h00);
    conclude();
  end
endmodule

`default_nettype wire
